// ---- src/mfd_pkg.sv ----
// Package for the microword fetch and field decode stage.
// Assumes one system clock; the microcycle is a count of clock cycles.
package mfd_pkg;
   localparam int CLK_NS = 10;
   localparam int MCYC_NS = 175;
   // A microcycle lasts at least its figure, so round up
   localparam int MCYC_CLKS = (MCYC_NS + CLK_NS - 1) / CLK_NS;
   localparam int MCYC_CW = 5;
   localparam logic [MCYC_CW-1:0] MCYC_LAST = MCYC_CW'(MCYC_CLKS - 1);

   localparam int UADDR_W = 12;
   localparam int UWORD_W = 32;
   localparam int STORE_DEPTH = 2048;
   localparam int STORE_AW = 11;

   // Microword bit n sits at vector index n
   localparam int SSEL_LSB = 0;
   localparam int STO_LSB = 5;
   localparam int FN_LSB = 10;
   localparam int TST_LSB = 15;
   localparam int SHF_LSB = 20;
   localparam int SPC_LSB = 23;
   localparam int RSEL_LSB = 28;
   localparam int SR_LO = 5;
   localparam int SR_HI = 27;
   localparam int SR_W = SR_HI - SR_LO + 1;

   localparam logic [UWORD_W-1:0] FR_RESET = 32'hFFFF_FFFF;
   localparam logic [SR_W-1:0] SR_NOP = 23'h7F_FFFF;
   localparam logic [UADDR_W-1:0] UADDR_RESET = 12'h000;
   localparam logic [1:0] NAME_RESET = 2'h0;

   // Store field codes
   localparam logic [4:0] STO_NONE = 5'h1F;
   localparam logic [4:0] STO_BUS_LOW = 5'h04;
   localparam logic [4:0] STO_BUS_SCR0 = 5'h05;
   localparam logic [4:0] STO_BUS_HIGH = 5'h06;
   localparam logic [4:0] STO_PUSH = 5'h1E;
   // Function field codes
   localparam logic [4:0] FN_REP_COND = 5'h1A;
   localparam logic [4:0] FN_REP_ALT = 5'h1B;
   localparam logic [4:0] FN_JUMP = 5'h1C;
   localparam logic [4:0] FN_CALL = 5'h1D;
   // Skip field codes; all others are condition tests
   localparam logic [4:0] TST_NONE = 5'h1F;
   localparam logic [4:0] TST_NEXT = 5'h1E;
   localparam logic [4:0] TST_RETURN = 5'h1D;
   // Shift and special field codes
   localparam logic [2:0] SHF_STRAIGHT = 3'h7;
   localparam logic [4:0] SPC_POP = 5'h1E;

   localparam logic [11:0] BUS_UNMAPPED = 12'h800;

   typedef struct packed {
      logic [4:0] store_sel;
      logic [4:0] alu_fn;
      logic [4:0] test_sel;
      logic [2:0] shift_sel;
      logic [4:0] special;
      logic special_en;
      logic [4:0] memopt;
      logic memopt_en;
      logic push;
      logic pop;
      logic next_instr;
      logic scratch_one_shift_en;
      logic scratch_three_shift_en;
      logic scratch_one_shift_in;
      logic scratch_three_shift_in;
   } mfd_ctl_t;

   // Physical slot for each of the four stack views
   typedef struct packed {
      logic [1:0] view_first;
      logic [1:0] view_second;
      logic [1:0] view_third;
      logic [1:0] view_fourth;
   } mfd_stack_map_t;
endpackage : mfd_pkg

// ---- src/mfd_store.sv ----
// Microprogram store: 2048 words of 32 bits, two registered read ports.
// Assumes the fetch port and the software port share sys_clk.
`timescale 1ns/100ps
module mfd_store
   import mfd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic fetch_en,
   input wire logic [UADDR_W-1:0] fetch_addr,
   output logic [UWORD_W-1:0] fetch_q,
   input wire logic [11:0] bus_addr,
   input wire logic [UWORD_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [UWORD_W-1:0] bus_rdata
);
   logic [UWORD_W-1:0] mem [STORE_DEPTH];
   logic bus_hit;

   assign bus_hit = (bus_addr < BUS_UNMAPPED);

   // Top microaddress bit falls outside the populated store
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fetch_q <= FR_RESET;
      end else if (fetch_en) begin
         fetch_q <= mem[fetch_addr[STORE_AW-1:0]];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (bus_wr && bus_hit) begin
         mem[bus_addr[STORE_AW-1:0]] <= bus_wdata;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bus_rdata <= 32'h0000_0000;
      end else if (bus_rd && bus_hit) begin
         bus_rdata <= mem[bus_addr[STORE_AW-1:0]];
      end else begin
         bus_rdata <= 32'h0000_0000;
      end
   end
endmodule : mfd_store

// ---- src/mfd_fetch_decode.sv ----
// Microword fetch, two-rank pipeline, repeat logic and field decode.
// Assumes the sequencer aligns its loads with ucyc_tick and that
// cond_true answers the executing test field in the same cycle.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module mfd_fetch_decode
   import mfd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic lut_load,
   input wire logic [UADDR_W-1:0] lut_addr,
   input wire logic [UADDR_W-1:0] jump_target,
   input wire logic cond_true,
   input wire logic name_load,
   input wire logic [1:0] name_value,
   input wire logic [11:0] bus_addr,
   input wire logic [UWORD_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [UWORD_W-1:0] bus_rdata,
   output logic ucyc_tick,
   output logic [UADDR_W-1:0] microaddress_register,
   output logic [UWORD_W-1:0] first_rank_microword,
   output logic [SR_W-1:0] second_rank_microword,
   output mfd_ctl_t ctl,
   output logic repeat_active,
   output mfd_stack_map_t stack_map_lines
);
   ////////////////////////////////////////////////////////////////////
   // Microcycle timing
   logic [MCYC_CW-1:0] cyc_cnt_r;
   logic tick_r;
   logic tick;

   assign tick = (cyc_cnt_r == MCYC_LAST);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cyc_cnt_r <= '0;
      end else if (tick) begin
         cyc_cnt_r <= '0;
      end else begin
         cyc_cnt_r <= cyc_cnt_r + 1'b1;
      end
   end

   // Announces the edge on which the sequencer may load
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= (cyc_cnt_r == MCYC_LAST - 1'b1);
      end
   end
   assign ucyc_tick = tick_r;

   ////////////////////////////////////////////////////////////////////
   // Decode of the executing word
   logic [UADDR_W-1:0] uaddr_r;
   logic [UADDR_W-1:0] uaddr_nxt;
   logic [UADDR_W-1:0] save_r;
   logic [UWORD_W-1:0] fr;
   logic [SR_W-1:0] sr_r;
   logic [SR_W-1:0] sr_nxt;
   logic rep_ff_r;
   logic fr_new_r;
   logic annul_r;
   logic [4:0] fn_x;
   logic [4:0] tst_x;
   logic [4:0] fn_fr;
   logic is_test;
   logic skip;
   logic jump_fn;
   logic jump;
   logic call;
   logic ret;
   logic repeat_set_pulse;
   logic repeat_inhibit;

   assign fn_x = sr_r[FN_LSB-SR_LO +: 5];
   assign tst_x = sr_r[TST_LSB-SR_LO +: 5];
   assign fn_fr = fr[FN_LSB +: 5];
   assign is_test = (tst_x != TST_NONE) && (tst_x != TST_NEXT) &&
                    (tst_x != TST_RETURN);
   assign jump_fn = (fn_x == FN_JUMP) || (fn_x == FN_CALL);
   // A coded jump takes the test as its gate instead of skipping
   assign jump = jump_fn && (!is_test || cond_true);
   assign call = jump && (fn_x == FN_CALL);
   assign skip = is_test && cond_true && !jump_fn;
   assign ret = (tst_x == TST_RETURN);

   // Repeat decode only counts on the first microcycle of a fresh word,
   // otherwise the frozen word would re-arm itself forever
   assign repeat_set_pulse = fr_new_r &&
      ((fn_fr == FN_REP_COND) || (fn_fr == FN_REP_ALT));
   assign repeat_inhibit = repeat_set_pulse || rep_ff_r;
   assign repeat_active = rep_ff_r;

   ////////////////////////////////////////////////////////////////////
   // Microaddress and save register
   always_comb begin
      uaddr_nxt = uaddr_r;
      if (lut_load) begin
         uaddr_nxt = lut_addr;
      end else if (ret) begin
         uaddr_nxt = save_r;
      end else if (jump) begin
         uaddr_nxt = jump_target;
      end else if (!repeat_inhibit) begin
         uaddr_nxt = uaddr_r + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         uaddr_r <= UADDR_RESET;
      end else if (tick) begin
         uaddr_r <= uaddr_nxt;
      end
   end
   assign microaddress_register = uaddr_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         save_r <= UADDR_RESET;
      end else if (tick && call) begin
         save_r <= uaddr_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // First rank lives in the store's fetch register
   mfd_store u_store (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .fetch_en(tick && !repeat_inhibit),
      .fetch_addr(uaddr_r),
      .fetch_q(fr),
      .bus_addr(bus_addr),
      .bus_wdata(bus_wdata),
      .bus_wr(bus_wr),
      .bus_rd(bus_rd),
      .bus_rdata(bus_rdata)
   );
   assign first_rank_microword = fr;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fr_new_r <= 1'b0;
      end else if (tick) begin
         fr_new_r <= !repeat_inhibit;
      end
   end

   // Set wins over a skip arriving in the same microcycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rep_ff_r <= 1'b0;
      end else if (tick) begin
         rep_ff_r <= repeat_set_pulse || (rep_ff_r && !skip);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Second rank
   // The word fetched behind a taken jump, return or start is dropped;
   // the one already in the first rank still runs as a delay slot.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         annul_r <= 1'b0;
      end else if (tick) begin
         annul_r <= lut_load || ret || jump;
      end
   end

   always_comb begin
      sr_nxt = fr[SR_HI:SR_LO];
      if (skip || annul_r) begin
         sr_nxt = SR_NOP;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sr_r <= SR_NOP;
      end else if (tick) begin
         sr_r <= sr_nxt;
      end
   end
   assign second_rank_microword = sr_r;

   ////////////////////////////////////////////////////////////////////
   // Field decoders, registered beside the second rank
   mfd_ctl_t ctl_nxt;
   mfd_ctl_t ctl_r;
   logic bus_store;

   always_comb begin
      ctl_nxt = '0;
      ctl_nxt.store_sel = sr_nxt[STO_LSB-SR_LO +: 5];
      ctl_nxt.alu_fn = sr_nxt[FN_LSB-SR_LO +: 5];
      ctl_nxt.test_sel = sr_nxt[TST_LSB-SR_LO +: 5];
      ctl_nxt.shift_sel = sr_nxt[SHF_LSB-SR_LO +: 3];
      bus_store = (ctl_nxt.store_sel == STO_BUS_LOW) ||
                  (ctl_nxt.store_sel == STO_BUS_HIGH) ||
                  (ctl_nxt.store_sel == STO_BUS_SCR0);
      if (bus_store) begin
         ctl_nxt.memopt = sr_nxt[SPC_LSB-SR_LO +: 5];
         ctl_nxt.memopt_en = 1'b1;
      end else begin
         ctl_nxt.special = sr_nxt[SPC_LSB-SR_LO +: 5];
         ctl_nxt.special_en = 1'b1;
         ctl_nxt.pop = (ctl_nxt.special == SPC_POP);
      end
      ctl_nxt.push = (ctl_nxt.store_sel == STO_PUSH);
      ctl_nxt.next_instr = (ctl_nxt.test_sel == TST_NEXT);
      ctl_nxt.scratch_one_shift_en = (ctl_nxt.shift_sel != SHF_STRAIGHT) &&
                                     !ctl_nxt.shift_sel[2];
      ctl_nxt.scratch_three_shift_en = (ctl_nxt.shift_sel != SHF_STRAIGHT) &&
                                       ctl_nxt.shift_sel[2];
      ctl_nxt.scratch_one_shift_in = ctl_nxt.shift_sel[0];
      ctl_nxt.scratch_three_shift_in = ctl_nxt.shift_sel[1];
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctl_r <= '0;
      end else if (tick) begin
         ctl_r <= ctl_nxt;
      end
   end
   assign ctl = ctl_r;

   ////////////////////////////////////////////////////////////////////
   // Name register and stack view map
   logic [1:0] name_r;
   logic [1:0] name_nxt;
   mfd_stack_map_t map_r;

   // Push moves the top one slot down, pop one slot up
   always_comb begin
      name_nxt = name_r;
      if (name_load) begin
         name_nxt = name_value;
      end else if (ctl_r.push && !ctl_r.pop) begin
         name_nxt = name_r - 1'b1;
      end else if (ctl_r.pop && !ctl_r.push) begin
         name_nxt = name_r + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         name_r <= NAME_RESET;
      end else if (tick) begin
         name_r <= name_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         map_r <= '{NAME_RESET, NAME_RESET + 2'd1, NAME_RESET + 2'd2,
                    NAME_RESET + 2'd3};
      end else begin
         map_r.view_first <= name_r;
         map_r.view_second <= name_r + 2'd1;
         map_r.view_third <= name_r + 2'd2;
         map_r.view_fourth <= name_r + 2'd3;
      end
   end
   assign stack_map_lines = map_r;

   ////////////////////////////////////////////////////////////////////
   // Checks
   tick_spacing_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick |=> !tick [*8] ##1 !tick [*8] ##1 !tick ##1 tick)
      else $error("microcycle not 18 clocks");

   addr_hold_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick && repeat_inhibit && !lut_load && !ret && !jump
      |=> $stable(uaddr_r))
      else $error("microaddress moved during repeat");

   addr_step_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick && !repeat_inhibit && !lut_load && !ret && !jump
      |=> uaddr_r == $past(uaddr_r) + 12'h001)
      else $error("microaddress did not step");

   rank_freeze_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick && repeat_inhibit |=> $stable(fr) && sr_r == $past(sr_nxt))
      else $error("first rank changed while repeating");

   repeat_set_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick && repeat_set_pulse |=> rep_ff_r)
      else $error("repeat flip-flop not set");

   repeat_clear_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick && rep_ff_r && skip && !repeat_set_pulse |=> !rep_ff_r)
      else $error("skip did not end repeat");

   skip_nop_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick && skip |=> sr_r == SR_NOP)
      else $error("skip did not load a no-op");

   rank_pass_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick && !skip && !annul_r |=> sr_r == $past(fr[SR_HI:SR_LO]))
      else $error("second rank missed first rank bits");

   opt_excl_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick |=> ctl_r.memopt_en != ctl_r.special_en)
      else $error("special and option decoders both on");

   return_load_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      tick && ret && !lut_load |=> uaddr_r == $past(save_r))
      else $error("return did not restore address");

   map_mod4_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      map_r.view_fourth == map_r.view_first + 2'd3 &&
      map_r.view_third == map_r.view_second + 2'd1)
      else $error("stack map not modulo four");
endmodule : mfd_fetch_decode

// ---- verif/mfd_seq_model.sv ----
// Stand-in for the microaddress sequencer and the datapath condition logic.
// Assumes the bench holds each request across the tick cycle that takes it.
`timescale 1ns/100ps
module mfd_seq_model
   import mfd_pkg::*;
(
   input wire logic ucyc_tick,
   input wire logic go_load,
   input wire logic [UADDR_W-1:0] start_addr,
   input wire logic [UADDR_W-1:0] jump_addr,
   input wire logic cond_req,
   input wire logic name_req,
   input wire logic [1:0] name_req_value,
   output logic lut_load,
   output logic [UADDR_W-1:0] lut_addr,
   output logic [UADDR_W-1:0] jump_target,
   output logic cond_true,
   output logic name_load,
   output logic [1:0] name_value
);
   ////////////////////////////////////////////////////////////////////////////////
   // Load and name requests show only in tick cycles, as a real sequencer aligns them
   assign lut_load = go_load & ucyc_tick;
   assign lut_addr = start_addr;
   // Target of coded jumps and calls, chosen by the bench
   assign jump_target = jump_addr;
   assign cond_true = cond_req;
   assign name_load = name_req & ucyc_tick;
   assign name_value = name_req_value;
endmodule : mfd_seq_model

// ---- verif/mfd_fetch_decode_tb.sv ----
// Self-checking bench for the microword fetch and decode stage.
// Assumes the store is loaded over the software port before the first tick.
`timescale 1ns/100ps
module mfd_fetch_decode_tb;
   import mfd_pkg::*;
   logic sys_clk, resetn, bus_wr, bus_rd, go_load, cond_req, name_req;
   logic [11:0] bus_addr, start_addr, jump_addr;
   logic [31:0] bus_wdata, bus_rdata;
   logic [1:0] name_req_value, name_value;
   logic lut_load, cond_true, name_load, ucyc_tick, repeat_active;
   logic [UADDR_W-1:0] lut_addr, jump_target, microaddress_register;
   logic [UWORD_W-1:0] first_rank_microword;
   logic [SR_W-1:0] second_rank_microword;
   mfd_ctl_t ctl;
   mfd_stack_map_t stack_map_lines;
   int bad_count, total_checks;
   logic [31:0] w [11];
   localparam logic [31:0] NOPW = 32'hFFFF_FFFF;
   localparam logic [11:0] JTGT = 12'h018;

   ////////////////////////////////////////////////////////////////////////////////
   mfd_seq_model seq_u (.ucyc_tick, .go_load, .start_addr, .cond_req, .name_req, .jump_addr,
      .name_req_value, .lut_load, .lut_addr, .jump_target, .cond_true, .name_load,
      .name_value);
   mfd_fetch_decode dut_u (.sys_clk, .resetn, .lut_load, .lut_addr, .jump_target,
      .cond_true, .name_load, .name_value, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
      .bus_rdata, .ucyc_tick, .microaddress_register, .first_rank_microword,
      .second_rank_microword, .ctl, .repeat_active, .stack_map_lines);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] mk(logic [4:0] s, sto, fn, tst, logic [2:0] shf,
      logic [4:0] spc, logic [3:0] r);
      return {r, spc, shf, tst, fn, sto, s};
   endfunction : mk

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task summarize;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic bus(input logic wr, rd, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_wr <= wr;
      bus_rd <= rd;
      bus_addr <= a;
      bus_wdata <= d;
   endtask : bus

   // Returns at the edge that ends a tick cycle; a lost tick ends the run
   task tk;
      for (int n = 0; n < 40; n++) begin
         @(negedge sys_clk);
         if (ucyc_tick === 1'b1) begin
            @(posedge sys_clk);
            return;
         end
      end
      bad_count++;
      summarize;
   endtask : tk

   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      #1 chk(32'(microaddress_register), 32'(UADDR_RESET));
      chk(first_rank_microword, FR_RESET);
      chk(32'(second_rank_microword), 32'(SR_NOP));
      chk({29'h0, repeat_active, ucyc_tick, 1'b0}, 32'h0);
      chk(32'(stack_map_lines), 32'h0000_001B);
   endtask : t_reset

   task t_bus;
      for (int i = 0; i < 11; i++) bus(1'b1, 1'b0, 12'h010 + 12'(i), w[i]);
      bus(1'b1, 1'b0, 12'h000, NOPW);
      bus(1'b1, 1'b0, 12'h01F, 32'h1234_5678);
      bus(1'b0, 1'b1, 12'h01F, 32'h0);
      bus(1'b0, 1'b1, BUS_UNMAPPED, 32'h0);
      #1 chk(bus_rdata, 32'h1234_5678);
      bus(1'b0, 1'b0, 12'h000, 32'h0);
      #1 chk(bus_rdata, 32'h0);
      @(posedge sys_clk) #1 chk(bus_rdata, 32'h0);
   endtask : t_bus

   task t_fetch;
      time t0;
      tk;
      t0 = $time;
      go_load <= 1'b0;
      tk;
      chk(32'(($time - t0) / 10), 32'(MCYC_CLKS));
      #1 chk(32'(microaddress_register), 32'h011);
      chk(first_rank_microword, w[0]);
      chk(32'(second_rank_microword), 32'(SR_NOP));
      tk;
      #1 chk(first_rank_microword, w[1]);
      chk(32'(second_rank_microword), 32'(w[0][27:5]));
      chk(32'({ctl.store_sel, ctl.push, ctl.pop, ctl.special_en}), {24'h0, STO_PUSH, 3'h7});
      chk(32'({ctl.special, ctl.alu_fn, ctl.shift_sel}), 32'({SPC_POP, 5'h00, 3'h7}));
      tk;
      cond_req <= 1'b1;
      #1 chk(first_rank_microword, w[2]);
      chk(32'({ctl.memopt_en, ctl.memopt, ctl.special_en}), 32'({1'b1, 5'h09, 1'b0}));
      chk(32'({ctl.store_sel, ctl.alu_fn, ctl.test_sel}), 32'({STO_BUS_LOW, 10'h0A0}));
      chk(32'({ctl.shift_sel, ctl.scratch_one_shift_en, ctl.scratch_three_shift_en,
         ctl.scratch_one_shift_in}), 32'h0000_0014);
      tk;
      cond_req <= 1'b0;
      #1 chk(32'(second_rank_microword), 32'(SR_NOP));
      chk(first_rank_microword, w[3]);
      chk(32'(microaddress_register), 32'h014);
   endtask : t_fetch

   task t_repeat;
      for (int i = 0; i < 2; i++) begin
         tk;
         cond_req <= 1'(i);
         #1 chk(32'(repeat_active), 32'h1);
         chk(32'(microaddress_register), 32'h014);
         chk(first_rank_microword, w[3]);
         chk(32'(second_rank_microword), 32'(w[3][27:5]));
      end
      tk;
      cond_req <= 1'b0;
      #1 chk(32'(repeat_active), 32'h0);
      tk;
      #1 chk(first_rank_microword, w[4]);
      chk(32'(microaddress_register), 32'h015);
   endtask : t_repeat

   task t_name;
      name_req <= 1'b1;
      name_req_value <= 2'h2;
      tk;
      name_req <= 1'b0;
      @(posedge sys_clk) #1 chk(32'(stack_map_lines), 32'h0000_00B1);
   endtask : t_name

   // Call runs its delay slot, drops the next fetch, and return restores the address
   task t_call;
      tk;
      #1 chk(32'({ctl.scratch_three_shift_en, ctl.scratch_three_shift_in}), 32'h2);
      chk(32'(ctl.next_instr), 32'h1);
      tk;
      #1 chk(32'(microaddress_register), 32'(JTGT));
      chk(32'(second_rank_microword), 32'(w[6][27:5]));
      tk;
      #1 chk(32'(second_rank_microword), 32'(SR_NOP));
      chk(first_rank_microword, w[8]);
      tk;
      tk;
      #1 chk(32'(microaddress_register), 32'h017);
   endtask : t_call

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      bad_count = 0;
      total_checks = 0;
      resetn = 1'b0;
      {bus_wr, bus_rd, go_load, cond_req, name_req} = 5'b00100;
      bus_addr = 12'h000;
      bus_wdata = 32'h0;
      start_addr = 12'h010;
      jump_addr = JTGT;
      name_req_value = 2'h0;
      w[0] = mk(5'h01, STO_PUSH, 5'h00, TST_NONE, SHF_STRAIGHT, SPC_POP, 4'h2);
      w[1] = mk(5'h03, STO_BUS_LOW, 5'h05, 5'h00, 3'h2, 5'h09, 4'h4);
      w[2] = mk(5'h07, STO_NONE, 5'h06, TST_NONE, SHF_STRAIGHT, 5'h00, 4'h6);
      w[3] = mk(5'h08, STO_NONE, FN_REP_COND, 5'h00, SHF_STRAIGHT, 5'h00, 4'h8);
      for (int i = 4; i < 11; i++) w[i] = NOPW;
      w[5] = mk(5'h1F, STO_NONE, FN_CALL, TST_NEXT, 3'h5, 5'h1F, 4'hF);
      w[8] = mk(5'h1F, STO_NONE, 5'h1F, TST_RETURN, SHF_STRAIGHT, 5'h1F, 4'hF);
      repeat (5) @(posedge sys_clk);
      t_reset;
      @(posedge sys_clk);
      resetn <= 1'b1;
      t_bus;
      t_fetch;
      t_repeat;
      t_name;
      t_call;
      summarize;
   end

   // The whole run takes well under ten microseconds
   initial begin
      #100us;
      bad_count++;
      summarize;
   end
endmodule : mfd_fetch_decode_tb
